// *** hw/hppc_pkg.sv ***
// Package of shared constants and types for the host port pin control ends.
package hppc_pkg;
   // Access-control target encodings.
   localparam logic [1:0] HPPC_SEL_CTRL = 2'h0;  // Control register.
   localparam logic [1:0] HPPC_SEL_DATA_INC = 2'h1;  // Data with auto-increment.
   localparam logic [1:0] HPPC_SEL_ADDR = 2'h2;  // Address register.
   localparam logic [1:0] HPPC_SEL_DATA = 2'h3;  // Data without auto-increment.
   // Cycles the device takes to finish an internal access.
   localparam logic [3:0] HPPC_ACCESS_CYCLES = 4'h4;
   // Reset values.
   localparam logic HPPC_PULLUP_RST = 1'b1;  // Pull-ups enabled after reset.
   localparam logic [15:0] HPPC_DATA_RST = 16'h0000;
   // Device states, one-hot.
   typedef enum logic [2:0] {
      HPPC_D_IDLE = 3'h1,
      HPPC_D_BUSY = 3'h2,
      HPPC_D_DONE = 3'h4
   } hppc_dev_st_t;
   // Host states, one-hot.
   typedef enum logic [3:0] {
      HPPC_H_IDLE = 4'h1,
      HPPC_H_STROBE = 4'h2,
      HPPC_H_WAIT = 4'h4,
      HPPC_H_END = 4'h8
   } hppc_host_st_t;
endpackage : hppc_pkg

// *** hw/hppc_if.sv ***
// Interface carrying the host port pins between host and device.
interface hppc_if;
   logic port_select_n;  // Active-low chip select.
   logic host_read_write_sel;  // 1 read, 0 write.
   logic host_strobe_a;  // Active-low data strobe A.
   logic host_strobe_b;  // Active-low data strobe B.
   logic access_ctrl_bit0;  // Target select bit 0.
   logic access_ctrl_bit1;  // Target select bit 1.
   logic byte_half_ident;  // First/second byte mark.
   logic port_enable_in;  // Port enable from host side.
   logic [15:0] host_data;  // Write data from host.
   logic [15:0] dev_data;  // Read data from device.
   logic dev_data_oe;  // Device drives read data.
   logic port_ready_out;  // Ready value.
   logic port_ready_oe;  // Ready driven.
   logic host_irq_n;  // Interrupt value.
   logic host_irq_oe;  // Interrupt driven.
   logic dev_in_reset;  // Device reset still held.
   modport dev (input port_select_n, host_read_write_sel, host_strobe_a, host_strobe_b,
      access_ctrl_bit0, access_ctrl_bit1, byte_half_ident, port_enable_in, host_data,
      output dev_data, dev_data_oe, port_ready_out, port_ready_oe, host_irq_n, host_irq_oe,
      dev_in_reset);
   modport host (output port_select_n, host_read_write_sel, host_strobe_a, host_strobe_b,
      access_ctrl_bit0, access_ctrl_bit1, byte_half_ident, port_enable_in, host_data,
      input dev_data, dev_data_oe, port_ready_out, port_ready_oe, host_irq_n, host_irq_oe,
      dev_in_reset);
endinterface : hppc_if

// *** hw/hppc_dev.sv ***
// Device end of the host port: pin control, ready pacing and register targets.
module hppc_dev import hppc_pkg::*; (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Pin side.
   hppc_if.dev pins,
   // Test and emulation pins.
   input wire logic test_reset,
   input wire logic emul_pin0,
   input wire logic emul_pin1_off_n,
   // Device-side controls.
   input wire logic gp_mode,  // High: pins serve as general inputs.
   input wire logic irq_set,  // Pulse: raise host interrupt.
   input wire logic irq_clr,  // Pulse: drop host interrupt.
   input wire logic pullup_wr,  // Pulse: load pull-up enables.
   input wire logic [5:0] pullup_wdata,
   // Device-side status.
   output logic [5:0] pullup_en,  // One per control pin.
   output logic [5:0] gp_inputs,  // Sampled control pins.
   output logic [15:0] ctrl_reg,
   output logic [15:0] addr_reg,
   output logic [15:0] data_reg,
   output logic wr_byte_second  // Last access, read or write, was second byte.
);
   // Whole module state. One packed word keeps the reset value and the update in a
   // single place, so no field can be forgotten in either.
   typedef struct packed {
      // Fields are listed in the same order as the reset value below.
      hppc_dev_st_t st;
      logic [3:0] cnt;
      logic started;  // Leaves reset at first edge.
      logic irq_n;
      logic [5:0] pull;
      logic [5:0] gp;
      logic [15:0] ctrl;
      logic [15:0] addr;
      logic [15:0] data;
      logic [15:0] rdata;
      logic rd;
      logic second;
   } hppc_dev_state_t;

   // Registered state and its next value.
   hppc_dev_state_t s_q, s_d;
   // Decoded views of the pins, shared by the next-state logic and the drivers.
   logic strobe;  // Either strobe low.
   logic selected;
   logic off_mode;
   logic [1:0] tsel;

   // Selection needs the chip select, the enable pin and the port function at once.
   // In general-purpose mode the pins still reach gp_inputs but never start an access.
   assign selected = !pins.port_select_n && pins.port_enable_in && !gp_mode;
   // Either strobe opens an access; a host may use whichever suits its bus.
   assign strobe = !pins.host_strobe_a || !pins.host_strobe_b;
   // OFF only floats the outputs; the registers keep their contents.
   assign off_mode = !test_reset && emul_pin0 && !emul_pin1_off_n;
   // Bit 1 is the high bit of the target code.
   assign tsel = {pins.access_ctrl_bit1, pins.access_ctrl_bit0};

   // Next-state logic for the transfer engine and side registers.
   // Every field starts from its registered value, so a branch that does not
   // name a field leaves it unchanged and no latch can form.
   always_comb begin
      s_d = s_q;
      // The first edge after reset marks the port as out of reset.
      s_d.started = 1'b1;
      // Control pins are always plain inputs; sample them for general use.
      // The sample costs one cycle of delay, which general-purpose use accepts.
      s_d.gp = {pins.port_select_n, pins.host_read_write_sel, pins.host_strobe_a,
         pins.host_strobe_b, pins.access_ctrl_bit0, pins.access_ctrl_bit1};
      // Software writes all six enables at once; there is no per-bit strobe.
      if (pullup_wr) begin
         s_d.pull = pullup_wdata;
      end
      // Set wins over clear, so an event that lands in the same cycle as the
      // host's acknowledge is never lost.
      if (irq_set) begin
         s_d.irq_n = 1'b0;
      end else if (irq_clr) begin
         // Clear only when no set arrives in the same cycle.
         s_d.irq_n = 1'b1;
      end
      // Transfer engine: idle, busy for the access time, then done until the strobe ends.
      unique case (s_q.st)
         // Idle: ready is high and the port waits for a strobe.
         HPPC_D_IDLE: begin
            // A strobe while selected starts one access.
            // Strobes while not selected are ignored entirely.
            if (selected && strobe) begin
               // Ready drops from the next edge until the access completes.
               s_d.st = HPPC_D_BUSY;
               s_d.cnt = HPPC_ACCESS_CYCLES;
               // Direction and byte mark are latched here, so later pin changes
               // during the access cannot alter what is being done.
               s_d.rd = pins.host_read_write_sel;
               s_d.second = pins.byte_half_ident;
               // Reads capture the target now; the host collects it when ready returns.
               if (pins.host_read_write_sel) begin
                  unique case (tsel)
                     HPPC_SEL_CTRL: s_d.rdata = s_q.ctrl;
                     HPPC_SEL_ADDR: s_d.rdata = s_q.addr;
                     default: s_d.rdata = s_q.data;
                  endcase
               end else begin
                  // Writes land at the edge that takes the strobe.
                  unique case (tsel)
                     HPPC_SEL_CTRL: s_d.ctrl = pins.host_data;
                     HPPC_SEL_ADDR: s_d.addr = pins.host_data;
                     default: s_d.data = pins.host_data;
                  endcase
               end
               // Auto-increment on the incrementing data target only, and only on the
               // second byte, so a two-byte host cycle steps the address once.
               if (tsel == HPPC_SEL_DATA_INC && pins.byte_half_ident) begin
                  s_d.addr = s_q.addr + 16'h0001;
               end
            end
         end
         // Busy: count down the internal access time.
         HPPC_D_BUSY: begin
            // Internal access time; ready stays low meanwhile, which holds the
            // host's strobe in place until the target has really been reached.
            s_d.cnt = s_q.cnt - 4'h1;
            // The last busy cycle hands over to DONE, where ready is high again.
            if (s_q.cnt == 4'h1) begin
               s_d.st = HPPC_D_DONE;
            end
         end
         HPPC_D_DONE: begin
            // Access finished: ready is high again, but a new access waits for the
            // strobe to end so one strobe is one access.
            if (!strobe) begin
               s_d.st = HPPC_D_IDLE;
            end
         end
         // An illegal state code returns to idle rather than hanging the port.
         default: s_d.st = HPPC_D_IDLE;
      endcase
   end

   // State register; no pin level is loaded under reset.
   // Reset takes only constants, so the asynchronous path never depends on a pin.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '{st: HPPC_D_IDLE,
            cnt: 4'h0,
            started: 1'b0,
            irq_n: 1'b1,
            pull: {6{HPPC_PULLUP_RST}},
            gp: 6'h3f,  // Idle control pins read high.
            ctrl: HPPC_DATA_RST,
            addr: HPPC_DATA_RST,
            data: HPPC_DATA_RST,
            rdata: HPPC_DATA_RST,
            rd: 1'b0,
            second: 1'b0};
      end else begin
         // Every field moves together on each edge.
         s_q <= s_d;
      end
   end

   // Pin drivers. Floating during reset keeps the host bus quiet while the part powers up.
   // The enables are combinational so that OFF and the enable pin float the
   // outputs at once, without waiting for a clock edge.
   logic drive_ok;  // All output pins may be driven.
   assign drive_ok = rstn && s_q.started && pins.port_enable_in && !off_mode;
   // Ready is driven whenever the outputs are; after reset it shows 1 at once.
   assign pins.port_ready_oe = drive_ok;
   // Ready is low only while the internal access runs. It is high in DONE, so
   // the host can see the access complete and end its strobe.
   assign pins.port_ready_out = (s_q.st != HPPC_D_BUSY);
   // The interrupt follows the same enable as ready and idles at 1.
   assign pins.host_irq_oe = drive_ok;
   assign pins.host_irq_n = s_q.irq_n;
   // Read data is driven only during a read strobe, so the host bus stays free
   // between accesses and while the host writes.
   assign pins.dev_data = s_q.rdata;
   assign pins.dev_data_oe = drive_ok && s_q.rd && (s_q.st != HPPC_D_IDLE) && strobe;
   // The host watches this to hold off requests until the port is out of reset.
   assign pins.dev_in_reset = !(rstn && s_q.started);

   // Device-side outputs.
   // All of them come straight from the state register, so they never glitch
   // while the pins move.
   assign pullup_en = s_q.pull;
   assign gp_inputs = s_q.gp;
   assign ctrl_reg = s_q.ctrl;
   assign addr_reg = s_q.addr;
   assign data_reg = s_q.data;
   assign wr_byte_second = s_q.second;
endmodule : hppc_dev

// *** hw/hppc_host.sv ***
// Host end of the host port: issues single reads and writes paced by ready.
module hppc_host import hppc_pkg::*; (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Pin side.
   hppc_if.host pins,
   // User request.
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_read,
   input wire logic [1:0] req_target,
   input wire logic req_second,
   input wire logic [15:0] req_wdata,
   input wire logic port_on,  // Drives the port enable pin.
   // User answer.
   output logic rsp_valid,  // One-cycle pulse.
   output logic [15:0] rsp_rdata
);
   // Whole module state.
   typedef struct packed {
      hppc_host_st_t st;
      logic sel_n;
      logic rw;
      logic strobe_n;
      logic [1:0] tgt;
      logic second;
      logic [15:0] wdata;
      logic rsp;
      logic busy_seen;  // Ready seen low since the strobe fell.
      logic [15:0] rdata;
   } hppc_host_state_t;

   hppc_host_state_t s_q, s_d;
   logic ready_seen;

   // Ready counts only when driven; a floating pin is not ready.
   assign ready_seen = pins.port_ready_oe && pins.port_ready_out;

   // Next state of the host sequencer.
   always_comb begin
      s_d = s_q;
      s_d.rsp = 1'b0;
      unique case (s_q.st)
         HPPC_H_IDLE: begin
            // No request while the device is still in reset.
            if (req_valid && !pins.dev_in_reset && ready_seen) begin
               s_d.st = HPPC_H_STROBE;
               s_d.sel_n = 1'b0;
               s_d.rw = req_read;
               s_d.tgt = req_target;
               s_d.second = req_second;
               s_d.wdata = req_wdata;
               s_d.busy_seen = 1'b0;
            end
         end
         HPPC_H_STROBE: begin
            s_d.strobe_n = 1'b0;
            s_d.st = HPPC_H_WAIT;
         end
         HPPC_H_WAIT: begin
            // Hold the strobe until the device reports done. Ready is still high at the
            // first edge after the strobe falls, before the device has taken it, so the
            // answer counts only once ready has been seen low.
            if (!ready_seen) begin
               s_d.busy_seen = 1'b1;
            end else if (s_q.busy_seen) begin
               s_d.rdata = pins.dev_data;
               s_d.strobe_n = 1'b1;
               s_d.sel_n = 1'b1;
               s_d.st = HPPC_H_END;
            end
         end
         HPPC_H_END: begin
            s_d.rsp = 1'b1;
            s_d.st = HPPC_H_IDLE;
         end
         default: s_d.st = HPPC_H_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '{st: HPPC_H_IDLE, sel_n: 1'b1, rw: 1'b1, strobe_n: 1'b1, tgt: 2'h0,
            second: 1'b0, wdata: 16'h0000, rsp: 1'b0, busy_seen: 1'b0, rdata: 16'h0000};
      end else begin
         s_q <= s_d;
      end
   end

   // Pin and user outputs.
   assign pins.port_select_n = s_q.sel_n;
   assign pins.host_read_write_sel = s_q.rw;
   assign pins.host_strobe_a = s_q.strobe_n;
   assign pins.host_strobe_b = 1'b1;  // Single-strobe use; the second strobe is idle.
   assign pins.access_ctrl_bit0 = s_q.tgt[0];
   assign pins.access_ctrl_bit1 = s_q.tgt[1];
   assign pins.byte_half_ident = s_q.second;
   assign pins.host_data = s_q.wdata;
   assign pins.port_enable_in = port_on;
   assign req_ready = (s_q.st == HPPC_H_IDLE) && !pins.dev_in_reset && ready_seen;
   assign rsp_valid = s_q.rsp;
   assign rsp_rdata = s_q.rdata;
endmodule : hppc_host

// *** tb/hppc_sva.sv ***
// Checker of the host port pins between the host and device ends.
module hppc_sva (
   // Clock and reset.
   input wire logic clk,
   input wire logic rstn,
   // Host driven pins.
   input wire logic port_select_n,
   input wire logic host_strobe_a,
   input wire logic host_strobe_b,
   input wire logic port_enable_in,
   // Device driven pins.
   input wire logic dev_data_oe,
   input wire logic port_ready_out,
   input wire logic port_ready_oe,
   input wire logic host_irq_n,
   input wire logic host_irq_oe,
   input wire logic dev_in_reset
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic strb_low;  // Either strobe asserted.
   assign strb_low = !host_strobe_a || !host_strobe_b;
   // A transfer is taken when an idle, selected port first sees a strobe.
   sequence s_take;
      !port_select_n && port_enable_in && port_ready_oe && port_ready_out && $rose(strb_low);
   endsequence
   // Ready stays low for the whole internal access, then returns.
   sequence s_busy;
      !port_ready_out [*4] ##1 port_ready_out;
   endsequence
   ready_busy_len_a: assert property (s_take |=> s_busy)
      else $error("ready low span wrong after strobe");
   reset_float_a: assert property (dev_in_reset |-> !port_ready_oe && !host_irq_oe)
      else $error("ready or irq driven in reset");
   ready_after_rst_a: assert property ($fell(dev_in_reset) && port_ready_oe |-> port_ready_out)
      else $error("ready not high after reset");
   irq_after_rst_a: assert property ($fell(dev_in_reset) && host_irq_oe |-> host_irq_n)
      else $error("irq not high after reset");
   enable_float_a: assert property (!port_enable_in && $past(port_enable_in) == 1'b0 |->
      !port_ready_oe && !host_irq_oe && !dev_data_oe)
      else $error("outputs driven while disabled");
   host_wait_rst_a: assert property (dev_in_reset |-> port_select_n && !strb_low)
      else $error("host access during reset");
   strobe_hold_a: assert property (port_ready_oe && !port_ready_out |-> strb_low && !port_select_n)
      else $error("strobe dropped while busy");
   strobe_release_a: assert property ($rose(port_ready_out) && strb_low |-> ##[1:3] !strb_low)
      else $error("strobe not released after ready");
endmodule : hppc_sva

// *** tb/tb_host_port_pin_control.sv ***
// Self-checking bench joining the host and device ends of the host port.
module tb_host_port_pin_control import hppc_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rstn = 1'b0, test_reset = 1'b1, emul_pin0 = 1'b0, emul_pin1_off_n = 1'b1, gp_mode = 1'b0;
   logic irq_set = 1'b0, irq_clr = 1'b0, pullup_wr = 1'b0, req_valid = 1'b0, req_read = 1'b0, req_second = 1'b0;
   logic port_on = 1'b1, wr_byte_second, req_ready, rsp_valid;
   logic [1:0] req_target = 2'h0;
   logic [5:0] pullup_wdata = 6'h00, pullup_en, gp_inputs, gp_exp;
   logic [15:0] req_wdata = 16'h0000, ctrl_reg, addr_reg, data_reg, rsp_rdata, rd, seed = 16'h0048;
   logic [15:0] e_ctrl = HPPC_DATA_RST, e_addr = HPPC_DATA_RST, e_data = HPPC_DATA_RST;
   int miscompares = 0, compares = 0;
   hppc_if bus ();
   // Free running 100 MHz clock.
   always #5 clk = ~clk;
   hppc_dev hppc_dev_inst (.clk(clk), .rstn(rstn), .pins(bus), .test_reset(test_reset), .emul_pin0(emul_pin0),
      .emul_pin1_off_n(emul_pin1_off_n), .gp_mode(gp_mode), .irq_set(irq_set), .irq_clr(irq_clr),
      .pullup_wr(pullup_wr), .pullup_wdata(pullup_wdata), .pullup_en(pullup_en), .gp_inputs(gp_inputs),
      .ctrl_reg(ctrl_reg), .addr_reg(addr_reg), .data_reg(data_reg), .wr_byte_second(wr_byte_second));
   hppc_host hppc_host_inst (.clk(clk), .rstn(rstn), .pins(bus), .req_valid(req_valid), .req_ready(req_ready),
      .req_read(req_read), .req_target(req_target), .req_second(req_second), .req_wdata(req_wdata),
      .port_on(port_on), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   hppc_sva hppc_sva_inst (.clk(clk), .rstn(rstn), .port_select_n(bus.port_select_n),
      .host_strobe_a(bus.host_strobe_a), .host_strobe_b(bus.host_strobe_b), .port_enable_in(bus.port_enable_in),
      .dev_data_oe(bus.dev_data_oe), .port_ready_out(bus.port_ready_out), .port_ready_oe(bus.port_ready_oe),
      .host_irq_n(bus.host_irq_n), .host_irq_oe(bus.host_irq_oe), .dev_in_reset(bus.dev_in_reset));
   // Compares one value and reports a mismatch at once.
   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         miscompares++;
      end
   endtask : chk
   // Prints the verdict and ends the run.
   task stop_test;
      if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // Pseudo random source, repeatable from its fixed start.
   function logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Address after a write: only a second byte to the incrementing data target steps it.
   function logic [15:0] next_addr(input logic [15:0] a, input logic [1:0] t, input logic s);
      return (t == HPPC_SEL_DATA_INC && s) ? a + 16'h0001 : a;
   endfunction : next_addr
   // One user request; the edge at entry keeps valid from being driven twice in one step.
   task xfer(input logic r, input logic [1:0] t, input logic s, input logic [15:0] w);
      int n;
      n = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req_read <= r;
      req_target <= t;
      req_second <= s;
      req_wdata <= w;
      do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 40);
      req_valid <= 1'b0;
      do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 80);
      chk("rsp_valid", 16'h0001, rsp_valid);
      rd = rsp_rdata;
      if (!r) begin
         if (t == HPPC_SEL_CTRL) e_ctrl = w;
         else if (t == HPPC_SEL_ADDR) e_addr = w;
         else e_data = w;
         e_addr = next_addr(e_addr, t, s);
         chk("wr_byte_second", s, wr_byte_second);
      end else begin
         chk("rsp_rdata", t == HPPC_SEL_CTRL ? e_ctrl : t == HPPC_SEL_ADDR ? e_addr : e_data, rd);
      end
      chk("ctrl_reg", e_ctrl, ctrl_reg);
      chk("addr_reg", e_addr, addr_reg);
      chk("data_reg", e_data, data_reg);
   endtask : xfer
   // Main sequence: reset, corner transfers, random traffic, then side pins.
   initial begin
      repeat (3) @(posedge clk);
      chk("ready_oe_rst", 16'h0000, bus.port_ready_oe);
      chk("irq_oe_rst", 16'h0000, bus.host_irq_oe);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("ready_after_rst", 16'h0001, {bus.port_ready_oe, bus.port_ready_out} == 2'h3);
      chk("irq_after_rst", 16'h0001, {bus.host_irq_oe, bus.host_irq_n} == 2'h3);
      chk("pullup_rst", {10'h000, {6{HPPC_PULLUP_RST}}}, pullup_en);
      xfer(1'b0, HPPC_SEL_ADDR, 1'b0, 16'hffff);
      xfer(1'b0, HPPC_SEL_DATA_INC, 1'b1, 16'ha5a5);
      xfer(1'b0, HPPC_SEL_DATA_INC, 1'b0, 16'h5a5a);
      xfer(1'b0, HPPC_SEL_CTRL, 1'b0, 16'h00ff);
      for (int t = 0; t < 4; t++) xfer(1'b1, t[1:0], 1'b0, 16'h0000);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         xfer(seed[0], seed[2:1], seed[3] & ~seed[0], lfsr(seed));
      end
      @(posedge clk);
      irq_set <= 1'b1;
      irq_clr <= 1'b1;
      @(posedge clk);
      irq_set <= 1'b0;
      irq_clr <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq_set_wins", 16'h0000, bus.host_irq_n);
      irq_clr <= 1'b1;
      pullup_wr <= 1'b1;
      pullup_wdata <= seed[5:0];
      gp_mode <= 1'b1;
      @(posedge clk);
      irq_clr <= 1'b0;
      pullup_wr <= 1'b0;
      repeat (2) @(posedge clk);
      chk("irq_cleared", 16'h0001, bus.host_irq_n);
      chk("pullup_en", {10'h000, seed[5:0]}, pullup_en);
      gp_exp = {bus.port_select_n, bus.host_read_write_sel, bus.host_strobe_a, bus.host_strobe_b,
         bus.access_ctrl_bit0, bus.access_ctrl_bit1};
      chk("gp_inputs", {10'h000, gp_exp}, gp_inputs);
      gp_mode <= 1'b0;
      test_reset <= 1'b0;
      emul_pin0 <= 1'b1;
      emul_pin1_off_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk("off_float", 16'h0000, bus.port_ready_oe | bus.host_irq_oe);
      test_reset <= 1'b1;
      port_on <= 1'b0;
      repeat (3) @(posedge clk);
      chk("enable_float", 16'h0000, bus.port_ready_oe | bus.host_irq_oe | bus.dev_data_oe);
      port_on <= 1'b1;
      repeat (2) @(posedge clk);
      xfer(1'b1, HPPC_SEL_DATA, 1'b0, 16'h0000);
      stop_test;
   end
   // Watchdog: the whole sequence needs well under a thousand cycles.
   initial begin
      #100000;
      miscompares++;
      stop_test;
   end
endmodule : tb_host_port_pin_control
